// *** bcc_top.sv ***
`timescale 1ns/10ps
`include "bcc_params.svh"

// ----------------------------------------------------------------------
// Common control register of the bus state controller
// ----------------------------------------------------------------------

// How it works
// RULE_01: bit 12 picks first or second map.
// RULE_02: bit 3 holds mode pin, read only.
// RULE_03: flag 0 big endian, 1 little endian.
// RULE_04: one byte-order flag for every space.
// RULE_05: bits 31..13 and 11..5 read zero.
// RULE_06: bits 4 and 2 always read one.
// RULE_07: bit 1 keeps memory pins driven in standby.
// RULE_08: bit 0 keeps clock pins driven in standby.
// RULE_09: software programs this before other areas.
// RULE_10: map decides usable areas and sizes.
// RULE_11: writes touch only the writable bits.
module bcc_top
#(
    parameter int MEM_PIN_W = 38,
    parameter int CLK_PIN_W = 4
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel.
    input wire logic awvalid,
    output logic awready,
    input wire logic [`BCC_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data channel.
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response channel.
    output logic bvalid,
    input wire logic bready,
    output bcc_pkg::bcc_resp_type bresp,
    // AXI4-Lite read address channel.
    input wire logic arvalid,
    output logic arready,
    input wire logic [`BCC_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data channel.
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output bcc_pkg::bcc_resp_type rresp,
    // Byte-order strap pin.
    input wire logic byte_order_mode_pin,
    // Settings used by the rest of the bus state controller.
    output bcc_pkg::bcc_map_type address_map,
    output bcc_pkg::bcc_endian_type bus_byte_order,
    output logic byte_order_valid,
    // Area decode of an external physical address.
    input wire logic [28:0] ext_addr,
    output logic [2:0] ext_area,
    output logic ext_area_usable,
    output logic ext_area_own_ctrl,
    // Standby request and the pad enables to gate.
    input wire logic standby,
    input wire logic [MEM_PIN_W-1:0] mem_pin_oe_req,
    input wire logic [CLK_PIN_W-1:0] clk_pin_oe_req,
    output logic [MEM_PIN_W-1:0] mem_pin_oe,
    output logic [CLK_PIN_W-1:0] clk_pin_oe
);

    import bcc_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------

    // Writable fields.
    logic map_q;
    logic map_d;
    logic memory_pin_standby_drive_q;
    logic memory_pin_standby_drive_d;
    logic clock_pin_standby_drive_q;
    logic clock_pin_standby_drive_d;
    // Byte-order flag and its capture control.
    logic endian_q;
    logic strap_taken_q;
    logic [1:0] settle_q;
    logic strap_sync;
    // Write channel holding state.
    logic aw_held_q;
    logic w_held_q;
    logic [`BCC_ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    bcc_resp_type bresp_q;
    // Read channel state.
    logic rvalid_q;
    logic [31:0] rdata_q;
    bcc_resp_type rresp_q;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------

    // The mode pin comes from outside and passes two flops first.
    bcc_sync2 u_strap_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(byte_order_mode_pin),
        .sync_out(strap_sync)
    );

    // Once the synchroniser has settled after release, the level is
    // taken once and then held until the next reset.
    logic strap_take;
    assign strap_take = !strap_taken_q && (settle_q == `BCC_STRAP_SETTLE);

    // Settle counter and one-time capture of the byte-order flag.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            settle_q <= 2'h0;
            strap_taken_q <= 1'h0;
            endian_q <= `BCC_ENDIAN_RESET;
        end
        else
        begin
            if (settle_q != `BCC_STRAP_SETTLE)
            begin
                settle_q <= settle_q + 2'h1;
            end
            if (strap_take)
            begin
                strap_taken_q <= 1'h1;
                endian_q <= strap_sync; // RULE_02 RULE_03
            end
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------

    // Each channel is taken while its holding slot is free and no response is pending.
    assign awready = !aw_held_q && !bvalid_q;
    assign wready = !w_held_q && !bvalid_q;

    logic aw_take;
    logic w_take;
    logic wr_commit;
    logic wr_hit;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign wr_commit = aw_held_q && w_held_q && !bvalid_q;
    assign wr_hit = ((waddr_q >> 2) == (`BCC_COMMON_CTRL_OFFSET >> 2));

    // Address and data are held in either order until both are here.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'h0;
            w_held_q <= 1'h0;
            waddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_q <= 1'h1;
                waddr_q <= awaddr;
            end
            else if (wr_commit)
            begin
                aw_held_q <= 1'h0;
            end
            if (w_take)
            begin
                w_held_q <= 1'h1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            else if (wr_commit)
            begin
                w_held_q <= 1'h0;
            end
        end
    end

    // Only the three writable bits follow a write, lane by lane; the
    // flag and the fixed bits have no storage that a write could reach.
    logic lane0_wr;
    logic lane1_wr;
    assign lane0_wr = wr_commit && wr_hit && wstrb_q[0];
    assign lane1_wr = wr_commit && wr_hit && wstrb_q[1];
    assign map_d = lane1_wr ? wdata_q[`BCC_MAP_BIT] : map_q; // RULE_11
    assign memory_pin_standby_drive_d =
        lane0_wr ? wdata_q[`BCC_MEM_DRIVE_BIT] : memory_pin_standby_drive_q; // RULE_11
    assign clock_pin_standby_drive_d =
        lane0_wr ? wdata_q[`BCC_CLK_DRIVE_BIT] : clock_pin_standby_drive_q; // RULE_11

    // Writable fields with their reset values.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            map_q <= `BCC_MAP_RESET; // RULE_01
            memory_pin_standby_drive_q <= `BCC_MEM_DRIVE_RESET; // RULE_07
            clock_pin_standby_drive_q <= `BCC_CLK_DRIVE_RESET; // RULE_08
        end
        else
        begin
            map_q <= map_d; // RULE_01
            memory_pin_standby_drive_q <= memory_pin_standby_drive_d;
            clock_pin_standby_drive_q <= clock_pin_standby_drive_d;
        end
    end

    // Response is raised when the write is committed and held for bready.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'h0;
            bresp_q <= BCC_RESP_OKAY;
        end
        else if (wr_commit)
        begin
            bvalid_q <= 1'h1;
            bresp_q <= wr_hit ? BCC_RESP_OKAY : BCC_RESP_SLVERR;
        end
        else if (bvalid_q && bready)
        begin
            bvalid_q <= 1'h0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------

    // Read image: reserved zero bits, fixed one bits, fields in place.
    logic [31:0] read_image;
    always_comb
    begin
        read_image = 32'h0000_0000; // RULE_05
        read_image[`BCC_MAP_BIT] = map_q;
        read_image[`BCC_ONE_HI_BIT] = 1'h1; // RULE_06
        read_image[`BCC_ENDIAN_BIT] = endian_q; // RULE_02
        read_image[`BCC_ONE_LO_BIT] = 1'h1; // RULE_06
        read_image[`BCC_MEM_DRIVE_BIT] = memory_pin_standby_drive_q;
        read_image[`BCC_CLK_DRIVE_BIT] = clock_pin_standby_drive_q;
    end

    logic ar_take;
    logic rd_hit;
    assign arready = !rvalid_q;
    assign ar_take = arvalid && arready;
    assign rd_hit = ((araddr >> 2) == (`BCC_COMMON_CTRL_OFFSET >> 2));

    // One read at a time; data appear the cycle after the address.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= BCC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'h1;
            rdata_q <= rd_hit ? read_image : 32'h0000_0000;
            rresp_q <= rd_hit ? BCC_RESP_OKAY : BCC_RESP_SLVERR;
        end
        else if (rvalid_q && rready)
        begin
            rvalid_q <= 1'h0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // ------------------------------------------------------------------
    // Settings to the controller
    // ------------------------------------------------------------------

    // A single flag sets the alignment of all spaces together.
    assign bus_byte_order = bcc_endian_type'(endian_q); // RULE_04
    assign byte_order_valid = strap_taken_q;
    assign address_map = bcc_map_type'(map_q); // RULE_01

    // ------------------------------------------------------------------
    // Area decode
    // ------------------------------------------------------------------

    // Bits 28..26 name the 64-Mbyte area; bit 25 splits it in halves.
    logic lower_half;
    logic full_area;
    logic half_area;
    assign ext_area = ext_addr[28:26];
    assign lower_half = !ext_addr[25];
    // Areas 0 and 3 are full size under either map.
    assign full_area = (ext_area == 3'h0) || (ext_area == 3'h3);
    // Areas 4 to 6 give the lower 32 Mbytes only under the first map.
    assign half_area = (ext_area == 3'h4) || (ext_area == 3'h5) || (ext_area == 3'h6);
    assign ext_area_usable = full_area
        || (half_area && (map_q || lower_half)); // RULE_10
    // Under the second map, areas 5 and 6 use their own control sets.
    assign ext_area_own_ctrl = map_q
        && ((ext_area == 3'h5) || (ext_area == 3'h6)); // RULE_10

    // ------------------------------------------------------------------
    // Standby pin control
    // ------------------------------------------------------------------

    // Address, strobes, selects, direction and byte masks.
    bcc_pin_gate #(.WIDTH(MEM_PIN_W)) u_mem_gate
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .oe_req(mem_pin_oe_req),
        .standby(standby),
        .keep_drive(memory_pin_standby_drive_q), // RULE_07
        .pin_oe(mem_pin_oe)
    );

    // Bus clock, clock enable, row and column strobes.
    bcc_pin_gate #(.WIDTH(CLK_PIN_W)) u_clk_gate
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .oe_req(clk_pin_oe_req),
        .standby(standby),
        .keep_drive(clock_pin_standby_drive_q), // RULE_08
        .pin_oe(clk_pin_oe)
    );

endmodule

// *** bcc_params.svh ***
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------

// Byte address of the common control register.
`define BCC_COMMON_CTRL_OFFSET 12'h000
// Number of byte address bits decoded by the slave.
`define BCC_ADDR_W 12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------

// Address-map select.
`define BCC_MAP_BIT 12
// Fixed-one reserved bit.
`define BCC_ONE_HI_BIT 4
// Byte-order flag, read only.
`define BCC_ENDIAN_BIT 3
// Fixed-one reserved bit.
`define BCC_ONE_LO_BIT 2
// Memory-pin standby drive.
`define BCC_MEM_DRIVE_BIT 1
// Clock-pin standby drive.
`define BCC_CLK_DRIVE_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------

// Address-map select after reset.
`define BCC_MAP_RESET 1'h0
// Memory-pin standby drive after reset.
`define BCC_MEM_DRIVE_RESET 1'h0
// Clock-pin standby drive after reset.
`define BCC_CLK_DRIVE_RESET 1'h0
// Byte-order flag while the strap has not been taken yet.
`define BCC_ENDIAN_RESET 1'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------

// Cycles after reset release before the synchronised strap is valid.
`define BCC_STRAP_SETTLE 2'h2

`endif

// *** bcc_pkg.sv ***
// ----------------------------------------------------------------------
// Types shared by the common control block
// ----------------------------------------------------------------------

package bcc_pkg;

    // AXI response codes.
    typedef enum logic [1:0]
    {
        BCC_RESP_OKAY = 2'b00,
        BCC_RESP_SLVERR = 2'b10
    } bcc_resp_type;

    // Active external address map.
    typedef enum logic
    {
        BCC_MAP_FIRST = 1'b0,
        BCC_MAP_SECOND = 1'b1
    } bcc_map_type;

    // Data alignment of all external spaces.
    typedef enum logic
    {
        BCC_BIG_ENDIAN = 1'b0,
        BCC_LITTLE_ENDIAN = 1'b1
    } bcc_endian_type;

endpackage

// *** bcc_sync2.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Two-flop synchroniser for a level arriving from a pin
// ----------------------------------------------------------------------

module bcc_sync2
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous level in, synchronised level out.
    input wire logic async_in,
    output logic sync_out
);

    // First stage; only the second stage reads it.
    logic meta_q;

    // Two stages clear to a constant under reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'h0;
            sync_out <= 1'h0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// *** bcc_pin_gate.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Standby gating of one group of output enables
// ----------------------------------------------------------------------

module bcc_pin_gate
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Enables wanted by the bus logic for this pin group.
    input wire logic [WIDTH-1:0] oe_req,
    // Standby state and the drive choice for standby.
    input wire logic standby,
    input wire logic keep_drive,
    // Registered enables to the pads.
    output logic [WIDTH-1:0] pin_oe
);

    // Pins float in standby unless software asked to keep them driven.
    logic [WIDTH-1:0] pin_oe_d;
    assign pin_oe_d = (standby && !keep_drive) ? '0 : oe_req;

    // The enables come from flip-flops and float during reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_oe <= '0;
        end
        else
        begin
            pin_oe <= pin_oe_d;
        end
    end

endmodule

// *** bcc_top_props.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------
// Port checker of the common control register
// ------------------------------------------------------------
module bcc_top_props
#(
    parameter int MEM_PIN_W = 38,
    parameter int CLK_PIN_W = 4
)
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire bcc_pkg::bcc_resp_type rresp,
    // Strap and settings.
    input wire logic byte_order_mode_pin,
    input wire bcc_pkg::bcc_map_type address_map,
    input wire bcc_pkg::bcc_endian_type bus_byte_order,
    input wire logic byte_order_valid,
    // Area decode.
    input wire logic [28:0] ext_addr,
    input wire logic [2:0] ext_area,
    input wire logic ext_area_usable,
    input wire logic ext_area_own_ctrl,
    // Standby gating.
    input wire logic standby,
    input wire logic [MEM_PIN_W-1:0] mem_pin_oe_req,
    input wire logic [CLK_PIN_W-1:0] clk_pin_oe_req,
    input wire logic [MEM_PIN_W-1:0] mem_pin_oe,
    input wire logic [CLK_PIN_W-1:0] clk_pin_oe
);
    import bcc_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A read or a whole write taken on this edge.
    sequence s_rd_take; arvalid && arready; endsequence
    sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
    // A fresh good or refused read answer.
    sequence s_rd_ok; $rose(rvalid) && rresp == BCC_RESP_OKAY; endsequence
    sequence s_rd_bad; $rose(rvalid) && rresp != BCC_RESP_OKAY; endsequence

    property p_rd_lat; s_rd_take |=> rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; s_wr_take |-> ##[1:2] bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_rd_fix;
        s_rd_ok |-> rdata[31:13] == 19'h0 && rdata[11:5] == 7'h0 && rdata[4] && rdata[2];
    endproperty
    a_rd_fix: assert property (p_rd_fix) else $error("fixed bits wrong");
    property p_rd_map; s_rd_ok |-> rdata[12] == address_map; endproperty
    a_rd_map: assert property (p_rd_map) else $error("map bit mismatch");
    property p_rd_end; s_rd_ok |-> rdata[3] == bus_byte_order; endproperty
    a_rd_end: assert property (p_rd_end) else $error("order flag mismatch");
    property p_rd_bad; s_rd_bad |-> rdata == 32'h0; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("refused read data");
    property p_strap;
        $rose(byte_order_valid) |-> bus_byte_order == $past(byte_order_mode_pin, 3);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured");
    property p_end_ro;
        byte_order_valid && $past(byte_order_valid) |-> $stable(bus_byte_order);
    endproperty
    a_end_ro: assert property (p_end_ro) else $error("order flag changed");
    property p_mem;
        $past(aresetn) && !$past(standby) |-> mem_pin_oe == $past(mem_pin_oe_req);
    endproperty
    a_mem: assert property (p_mem) else $error("memory pin enable wrong");
    property p_clk;
        $past(aresetn) && !$past(standby) |-> clk_pin_oe == $past(clk_pin_oe_req);
    endproperty
    a_clk: assert property (p_clk) else $error("clock pin enable wrong");
    property p_own;
        ext_area == ext_addr[28:26] && ext_area_own_ctrl ==
            (address_map == BCC_MAP_SECOND && (ext_area == 3'h5 || ext_area == 3'h6));
    endproperty
    a_own: assert property (p_own) else $error("area decode wrong");
endmodule

bind bcc_top bcc_top_props #(.MEM_PIN_W(MEM_PIN_W), .CLK_PIN_W(CLK_PIN_W)) u_props
(
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
    .byte_order_mode_pin(byte_order_mode_pin), .address_map(address_map),
    .bus_byte_order(bus_byte_order), .byte_order_valid(byte_order_valid),
    .ext_addr(ext_addr), .ext_area(ext_area), .ext_area_usable(ext_area_usable),
    .ext_area_own_ctrl(ext_area_own_ctrl), .standby(standby),
    .mem_pin_oe_req(mem_pin_oe_req), .clk_pin_oe_req(clk_pin_oe_req),
    .mem_pin_oe(mem_pin_oe), .clk_pin_oe(clk_pin_oe)
);

// *** bcc_mem_model.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------
// External memory as seen through its pads
// ------------------------------------------------------------
module bcc_mem_model
#(
    parameter int MW = 38,
    parameter int CW = 4
)
(
    // Pad enables from the controller.
    input wire logic [MW-1:0] mem_pin_oe,
    input wire logic [CW-1:0] clk_pin_oe,
    // High while every pin of the group is released to its pull.
    output logic mem_float,
    output logic clk_float
);
    // Released pads sit at the pull level, so the memory sees idle pins.
    assign mem_float = (mem_pin_oe == '0);
    assign clk_float = (clk_pin_oe == '0);
endmodule

// *** tb_bus_common_control.sv ***
`timescale 1ns/10ps

module tb_bus_common_control;
    import bcc_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, stby;
    logic awready, wready, bvalid, arready, rvalid, amap, bord, bvld, usable, own;
    logic mflt, cflt, e;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rs, d, cur;
    logic [3:0] wstrb, creq, coe;
    logic [37:0] mreq, moe;
    logic [28:0] eaddr;
    logic [2:0] area;
    logic [1:0] bresp, rresp, resp;
    int n_errors, total_checks, k, i, v;

    bcc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .byte_order_mode_pin(pin), .address_map(amap),
        .bus_byte_order(bord), .byte_order_valid(bvld), .ext_addr(eaddr), .ext_area(area),
        .ext_area_usable(usable), .ext_area_own_ctrl(own), .standby(stby),
        .mem_pin_oe_req(mreq), .clk_pin_oe_req(creq), .mem_pin_oe(moe), .clk_pin_oe(coe));
    bcc_mem_model u_mem (.mem_pin_oe(moe), .clk_pin_oe(coe), .mem_float(mflt),
        .clk_float(cflt));

    // Free-running bus clock.
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Watchdog against a hung run.
    initial
    begin
        repeat (90000) @(posedge aclk);
        n_errors++;
        results();
    end

    task results;
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [63:0] g, input logic [63:0] x);
        total_checks++;
        if (g !== x)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    function logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Register image expected from the writable bits and the strap.
    function logic [31:0] img_of(input logic [31:0] c, input logic f);
        img_of = {19'h0, c[12], 7'h0, 1'b1, f, 1'b1, c[1:0]};
    endfunction

    // Only lane 1 reaches the map bit and lane 0 the drive bits.
    function logic [31:0] upd(input logic [31:0] c, input logic [31:0] w, input logic [3:0] s);
        upd = c;
        if (s[1])
            upd[12] = w[12];
        if (s[0])
            upd[1:0] = w[1:0];
    endfunction

    function logic use_of(input logic m, input logic [28:0] a);
        use_of = a[28:26] == 3'h0 || a[28:26] == 3'h3 ||
            a[28:26] inside {3'h4, 3'h5, 3'h6} && (m || !a[25]);
    endfunction

    // One write: both channels offered at once, each dropped when taken.
    task wr(input logic [11:0] a, input logic [31:0] w, input logic [3:0] s);
        int n;
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= w;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tb)
            begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50)
        begin
            n_errors++;
            results();
        end
    endtask

    // One read, data and response taken at the answering edge.
    task rd(input logic [11:0] a);
        int n;
        logic ta, tb;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(negedge aclk);
            ta = arvalid & arready;
            tb = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta)
                arvalid <= 1'b0;
            if (tb)
            begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50)
        begin
            n_errors++;
            results();
        end
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, pin, stby} = 8'h0;
        {awaddr, araddr, wdata, wstrb, creq, mreq, eaddr} = '0;
        rs = 32'hCC5887AA;
        for (k = 0; k < 2; k++)
        begin
            // Power-on reset; random strap first, then the other level.
            rs = nxt(rs);
            e = (k == 0) ? rs[0] : !e;
            @(posedge aclk);
            aresetn <= 1'b0;
            pin <= e;
            repeat (20) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (2) @(posedge aclk);
            chk(bvld, 1'b0);
            repeat (3) @(posedge aclk);
            cur = 32'h0;
            rd(12'h000);
            chk(d, img_of(cur, e));
            chk(bord, e);
            chk(bvld, 1'b1);
            // Random and corner writes, reserved bits and lanes included.
            for (i = 0; i < 12; i++)
            begin
                rs = nxt(rs);
                wr(12'h000, rs, i < 4 ? 4'hF : (i == 4 ? 4'h0 : rs[7:4]));
                cur = upd(cur, rs, i < 4 ? 4'hF : (i == 4 ? 4'h0 : rs[7:4]));
                chk(resp, BCC_RESP_OKAY);
                rd(12'h000);
                chk(d, img_of(cur, e));
                chk(amap, cur[12]);
            end
            // Unmapped word: refused, register untouched.
            wr({rs[11:2] | 10'h1, 2'h0}, ~cur, 4'hF);
            chk(resp, BCC_RESP_SLVERR);
            rd({rs[11:2] | 10'h1, 2'h0});
            chk(d, 32'h0);
            chk(resp, BCC_RESP_SLVERR);
            rd(12'h000);
            chk(d, img_of(cur, e));
            // Standby with every drive setting; map follows the pass.
            for (v = 0; v < 4; v++)
            begin
                wr(12'h000, {19'h0, k[0], 7'h0, 3'h5, v[1:0]}, 4'hF);
                cur = {19'h0, k[0], 10'h0, v[1:0]};
                rs = nxt(rs);
                stby <= 1'b1;
                mreq <= {rs[5:0], rs} | 38'h1;
                creq <= rs[11:8] | 4'h1;
                repeat (3) @(posedge aclk);
                chk(moe, v[1] ? mreq : 38'h0);
                chk(coe, v[0] ? creq : 4'h0);
                chk(mflt, !v[1]);
                chk(cflt, !v[0]);
                stby <= 1'b0;
                repeat (2) @(posedge aclk);
                chk(moe, mreq);
            end
            rd(12'h000);
            chk(d, img_of(cur, e));
            // Area traffic only once the register is set up.
            for (i = 0; i < 16; i++)
            begin
                rs = nxt(rs);
                @(posedge aclk);
                eaddr <= {i[2:0], rs[25:0]};
                @(negedge aclk);
                chk(area, i[2:0]);
                chk(usable, use_of(cur[12], {i[2:0], rs[25:0]}));
                chk(own, cur[12] && i[2:0] inside {3'h5, 3'h6});
            end
        end
        results();
    end
endmodule
